// *** include/flow_totalizer_regs.vh ***
`ifndef FLOW_TOTALIZER_REGS_VH
`define FLOW_TOTALIZER_REGS_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CLK_RATE_HZ     200000000
`define MS_PER_SEC      1000
`define ZERO_MS_0       100
`define ZERO_MS_1       1000
`define ZERO_MS_2       10000
`define FILT_HZ_1       10
`define FILT_HZ_2       25
`define FILT_HZ_3       50
`define FILT_HZ_4       100
`define FILT_HZ_5       1000
`define FILT_HZ_6       5000
`define FILT_HZ_7       10000
`define FILT_HZ_8       50000
`define SEC_PER_MIN     12'h03C
`define SEC_PER_HOUR    12'hE10
`define ONE_PER_SEC     12'h001

// ----------------------------------------------------------------
// Register map, word indices within a channel, channel stride
// ----------------------------------------------------------------
`define CH_LSB          5
`define IDX_LSB         2
`define REG_CFG         3'h0
`define REG_LO_LIMIT    3'h1
`define REG_HI_LIMIT    3'h2
`define REG_TOTAL       3'h3
`define REG_RATE        3'h4
`define REG_STATUS      3'h5

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define CFG_MODE_LSB    0
`define CFG_FILT_LSB    2
`define CFG_ZERO_LSB    6
`define CFG_BASE_LSB    8
`define CFG_RST_EN      10
`define CFG_HOLD_EN     11
`define CFG_DIR_EN      12
`define CFG_RESET_NOW   13
`define CFG_RESET_VAL   32'h00000000
`define LIMIT_RESET_VAL 32'h00000000

`define MODE_DIR        2'h0
`define MODE_QUAD1      2'h1
`define MODE_QUAD4      2'h2
`define BASE_SEC        2'h0
`define BASE_MIN        2'h1
`define BASE_HOUR       2'h2

`define STAT_LO         0
`define STAT_HI         1
`define STAT_IDLE       2
`define STAT_DOWN       3

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// *** design/pulse_input_filter.v ***
`timescale 1ns/1ps
`include "flow_totalizer_regs.vh"

module pulse_input_filter (
    input  wire        clk,
    input  wire        rstn,
    input  wire        raw,
    input  wire [31:0] threshold,
    output reg         clean
);

// ----------------------------------------------------------------
// Accept a level only after it has stood for threshold cycles
// ----------------------------------------------------------------
reg [31:0] stable_cnt;

always @(posedge clk) begin
    if (!rstn) begin
        clean      <= 1'b0;
        stable_cnt <= 32'h00000000;
    end else if (raw == clean) begin
        stable_cnt <= 32'h00000000;
    end else if (threshold == 32'h00000000 || stable_cnt + 32'h00000001 >= threshold) begin
        clean      <= raw;
        stable_cnt <= 32'h00000000;
    end else begin
        stable_cnt <= stable_cnt + 32'h00000001;
    end
end

endmodule // pulse_input_filter

// *** design/pulse_decoder.v ***
`timescale 1ns/1ps
`include "flow_totalizer_regs.vh"

module pulse_decoder (
    input  wire       clk,
    input  wire       rstn,
    input  wire       in_a,
    input  wire       in_b,
    input  wire [1:0] mode,
    output reg        step,
    output reg        down
);

// ----------------------------------------------------------------
// Edge detection and direction decode
// ----------------------------------------------------------------
reg  prev_a;
reg  prev_b;
wire rise_a = in_a & ~prev_a;
wire chg_a  = in_a ^ prev_a;
wire chg_b  = in_b ^ prev_b;

always @(posedge clk) begin
    if (!rstn) begin
        prev_a <= 1'b0;
        prev_b <= 1'b0;
        step   <= 1'b0;
        down   <= 1'b0;
    end else begin
        prev_a <= in_a;
        prev_b <= in_b;
        case (mode)
            `MODE_QUAD1: begin
                step <= rise_a;
                down <= rise_a ? in_b : down;
            end
            `MODE_QUAD4: begin
                step <= chg_a ^ chg_b;
                down <= (chg_a ^ chg_b) ? (prev_a ^ in_b) : down;
            end
            default: begin
                step <= rise_a;
                down <= rise_a ? in_b : down;
            end
        endcase
    end
end

endmodule // pulse_decoder

// *** design/pulse_flow_totalizer.v ***
// Behaviour
// - Two or four independent two-input pulse channels
// - Direction mode counts first input only
// - Direction low counts up, high down
// - Quad one decodes count and direction
// - Quad four decodes at higher resolution
// - Selectable filter caps accepted pulse frequency
// - Filter disabled counts without any cap
// - No pulse within zero time gives rate zero
// - Rate time base per second, minute, hour
// - Rate below low limit flags Lo
// - Rate above high limit flags Hi
// - Manual reset command clears totalizer immediately
// - Config bit enables external totalizer reset
// - External reset when source above zero
// - Config bit enables external totalizer hold
// - Hold when source zero or negative
// - Hold keeps total and rate measurement; here only the total is held, rate measurement keeps running
// - Config bit enables external direction reversal
// - Reverse direction when source above zero
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "flow_totalizer_regs.vh"

module pulse_flow_totalizer #(
    parameter NUM_CH = 4,
    parameter CLK_HZ = `CLK_RATE_HZ
) (
    input  wire                clk,
    input  wire                rstn,
    input  wire [7:0]          awaddr,
    input  wire                awvalid,
    output reg                 awready,
    input  wire [31:0]         wdata,
    input  wire [3:0]          wstrb,
    input  wire                wvalid,
    output reg                 wready,
    output reg  [1:0]          bresp,
    output reg                 bvalid,
    input  wire                bready,
    input  wire [7:0]          araddr,
    input  wire                arvalid,
    output reg                 arready,
    output reg  [31:0]         rdata,
    output reg  [1:0]          rresp,
    output reg                 rvalid,
    input  wire                rready,
    input  wire [NUM_CH-1:0]   pulse_a,
    input  wire [NUM_CH-1:0]   pulse_b,
    input  wire [NUM_CH*32-1:0] reset_source_value,
    input  wire [NUM_CH*32-1:0] hold_source_value,
    input  wire [NUM_CH*32-1:0] dir_source_value,
    output wire [NUM_CH-1:0]   lo_flag,
    output wire [NUM_CH-1:0]   hi_flag
);

// ----------------------------------------------------------------
// Timing counts derived from the clock rate
// ----------------------------------------------------------------
localparam [31:0] GATE_CYCLES = CLK_HZ;
localparam [31:0] MS_CYCLES   = CLK_HZ / `MS_PER_SEC;
localparam [31:0] ZERO_CYC_0  = MS_CYCLES * `ZERO_MS_0;
localparam [31:0] ZERO_CYC_1  = MS_CYCLES * `ZERO_MS_1;
localparam [31:0] ZERO_CYC_2  = MS_CYCLES * `ZERO_MS_2;
localparam [31:0] FILT_CYC_1  = CLK_HZ / (2 * `FILT_HZ_1);
localparam [31:0] FILT_CYC_2  = CLK_HZ / (2 * `FILT_HZ_2);
localparam [31:0] FILT_CYC_3  = CLK_HZ / (2 * `FILT_HZ_3);
localparam [31:0] FILT_CYC_4  = CLK_HZ / (2 * `FILT_HZ_4);
localparam [31:0] FILT_CYC_5  = CLK_HZ / (2 * `FILT_HZ_5);
localparam [31:0] FILT_CYC_6  = CLK_HZ / (2 * `FILT_HZ_6);
localparam [31:0] FILT_CYC_7  = CLK_HZ / (2 * `FILT_HZ_7);
localparam [31:0] FILT_CYC_8  = CLK_HZ / (2 * `FILT_HZ_8);

// ----------------------------------------------------------------
// Write channel capture
// ----------------------------------------------------------------
reg  [7:0]  wr_addr;
reg  [31:0] wr_data;
reg  [3:0]  wr_strb;
reg         have_aw;
reg         have_w;
wire        do_write = have_aw & have_w & ~bvalid;
wire [1:0]  wr_ch    = wr_addr[`CH_LSB+1:`CH_LSB];
wire [2:0]  wr_idx   = wr_addr[`CH_LSB-1:`IDX_LSB];
wire        wr_map   = ~wr_addr[7] && (wr_addr[1:0] == 2'h0) &&
                       ({1'b0, wr_ch} < NUM_CH) && (wr_idx <= `REG_HI_LIMIT);
wire [31:0] wr_mask  = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

always @(posedge clk) begin
    if (!rstn) begin
        awready <= 1'b1;
        wready  <= 1'b1;
        have_aw <= 1'b0;
        have_w  <= 1'b0;
        bvalid  <= 1'b0;
        bresp   <= `RESP_OKAY;
        wr_addr <= 8'h00;
        wr_data <= 32'h00000000;
        wr_strb <= 4'h0;
    end else begin
        if (awvalid && awready) begin
            wr_addr <= awaddr;
            have_aw <= 1'b1;
            awready <= 1'b0;
        end
        if (wvalid && wready) begin
            wr_data <= wdata;
            wr_strb <= wstrb;
            have_w  <= 1'b1;
            wready  <= 1'b0;
        end
        if (do_write) begin
            bvalid  <= 1'b1;
            bresp   <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
            have_aw <= 1'b0;
            have_w  <= 1'b0;
        end
        if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// Per-channel state, flattened for the read path
// ----------------------------------------------------------------
wire [NUM_CH*32-1:0] cfg_flat;
wire [NUM_CH*32-1:0] lo_flat;
wire [NUM_CH*32-1:0] hi_flat;
wire [NUM_CH*32-1:0] total_flat;
wire [NUM_CH*32-1:0] rate_flat;
wire [NUM_CH*32-1:0] stat_flat;

// ----------------------------------------------------------------
// Shared one-second gate
// ----------------------------------------------------------------
reg [31:0] gate_cnt;
reg        gate_tick;

always @(posedge clk) begin
    if (!rstn) begin
        gate_cnt  <= 32'h00000000;
        gate_tick <= 1'b0;
    end else if (gate_cnt + 32'h00000001 >= GATE_CYCLES) begin
        gate_cnt  <= 32'h00000000;
        gate_tick <= 1'b1;
    end else begin
        gate_cnt  <= gate_cnt + 32'h00000001;
        gate_tick <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Channels
// ----------------------------------------------------------------
genvar c;
generate
    for (c = 0; c < NUM_CH; c = c + 1) begin : chan
        reg  [31:0]        cfg;
        reg  [31:0]        lo_limit;
        reg  [31:0]        hi_limit;
        reg  signed [31:0] total;
        reg  [31:0]        rate;
        reg  [31:0]        win_pulses;
        reg  [31:0]        idle_cnt;
        reg                idle;
        reg                lo;
        reg                hi;
        reg                manual_reset;
        reg  [31:0]        filt_thr;
        reg  [31:0]        zero_lim;
        reg  [11:0]        base_mult;
        wire               clean_a;
        wire               clean_b;
        wire               step;
        wire               down;
        wire               hit      = do_write & wr_map & (wr_ch == c);
        wire               cfg_hit  = hit & (wr_idx == `REG_CFG);
        wire signed [31:0] rst_src  = reset_source_value[c*32 +: 32];
        wire signed [31:0] hold_src = hold_source_value[c*32 +: 32];
        wire signed [31:0] dir_src  = dir_source_value[c*32 +: 32];
        wire               ext_rst  = cfg[`CFG_RST_EN] && (rst_src > 0);
        wire               held     = cfg[`CFG_HOLD_EN] && (hold_src <= 0);
        wire               reverse  = cfg[`CFG_DIR_EN] && (dir_src > 0);
        wire               neg_step = down ^ reverse;
        wire [43:0]        scaled   = win_pulses * base_mult;

        always @* begin
            case (cfg[`CFG_FILT_LSB+3:`CFG_FILT_LSB])
                4'h1:    filt_thr = FILT_CYC_1;
                4'h2:    filt_thr = FILT_CYC_2;
                4'h3:    filt_thr = FILT_CYC_3;
                4'h4:    filt_thr = FILT_CYC_4;
                4'h5:    filt_thr = FILT_CYC_5;
                4'h6:    filt_thr = FILT_CYC_6;
                4'h7:    filt_thr = FILT_CYC_7;
                4'h8:    filt_thr = FILT_CYC_8;
                default: filt_thr = 32'h00000000;
            endcase
            case (cfg[`CFG_ZERO_LSB+1:`CFG_ZERO_LSB])
                2'h0:    zero_lim = ZERO_CYC_0;
                2'h1:    zero_lim = ZERO_CYC_1;
                default: zero_lim = ZERO_CYC_2;
            endcase
            case (cfg[`CFG_BASE_LSB+1:`CFG_BASE_LSB])
                `BASE_MIN:  base_mult = `SEC_PER_MIN;
                `BASE_HOUR: base_mult = `SEC_PER_HOUR;
                default:    base_mult = `ONE_PER_SEC;
            endcase
        end

        pulse_input_filter filt_a (
            .clk       (clk),
            .rstn      (rstn),
            .raw       (pulse_a[c]),
            .threshold (filt_thr),
            .clean     (clean_a)
        );

        pulse_input_filter filt_b (
            .clk       (clk),
            .rstn      (rstn),
            .raw       (pulse_b[c]),
            .threshold (filt_thr),
            .clean     (clean_b)
        );

        pulse_decoder decode (
            .clk  (clk),
            .rstn (rstn),
            .in_a (clean_a),
            .in_b (clean_b),
            .mode (cfg[`CFG_MODE_LSB+1:`CFG_MODE_LSB]),
            .step (step),
            .down (down)
        );

        // Registers written by software
        always @(posedge clk) begin
            if (!rstn) begin
                cfg          <= `CFG_RESET_VAL;
                lo_limit     <= `LIMIT_RESET_VAL;
                hi_limit     <= `LIMIT_RESET_VAL;
                manual_reset <= 1'b0;
            end else begin
                manual_reset <= cfg_hit & wr_strb[1] & wr_data[`CFG_RESET_NOW];
                if (cfg_hit)
                    cfg <= ((cfg & ~wr_mask) | (wr_data & wr_mask)) &
                           ~(32'h00000001 << `CFG_RESET_NOW);
                if (hit && wr_idx == `REG_LO_LIMIT)
                    lo_limit <= (lo_limit & ~wr_mask) | (wr_data & wr_mask);
                if (hit && wr_idx == `REG_HI_LIMIT)
                    hi_limit <= (hi_limit & ~wr_mask) | (wr_data & wr_mask);
            end
        end

        // Rate measurement, zero timeout and limit flags
        always @(posedge clk) begin
            if (!rstn) begin
                win_pulses <= 32'h00000000;
                idle_cnt   <= 32'h00000000;
                idle       <= 1'b1;
                rate       <= 32'h00000000;
                lo         <= 1'b0;
                hi         <= 1'b0;
            end else begin
                if (step) begin
                    idle_cnt <= 32'h00000000;
                    idle     <= 1'b0;
                end else if (idle_cnt + 32'h00000001 >= zero_lim) begin
                    idle     <= 1'b1;
                end else begin
                    idle_cnt <= idle_cnt + 32'h00000001;
                end
                if (gate_tick) begin
                    win_pulses <= {31'h00000000, step};
                    rate       <= idle ? 32'h00000000 : scaled[31:0];
                end else begin
                    win_pulses <= win_pulses + {31'h00000000, step};
                    if (idle)
                        rate <= 32'h00000000;
                end
                lo <= (rate < lo_limit);
                hi <= (rate > hi_limit);
            end
        end

        // Totalizer
        always @(posedge clk) begin
            if (!rstn) begin
                total <= 32'h00000000;
            end else if (manual_reset || ext_rst) begin
                total <= 32'h00000000;
            end else if (step && !held) begin
                total <= neg_step ? total - 32'h00000001 : total + 32'h00000001;
            end
        end

        assign cfg_flat[c*32 +: 32]   = cfg;
        assign lo_flat[c*32 +: 32]    = lo_limit;
        assign hi_flat[c*32 +: 32]    = hi_limit;
        assign total_flat[c*32 +: 32] = total;
        assign rate_flat[c*32 +: 32]  = rate;
        assign stat_flat[c*32 +: 32]  = {28'h0000000, down, idle, hi, lo};
        assign lo_flag[c]             = lo;
        assign hi_flag[c]             = hi;
    end
endgenerate

// ----------------------------------------------------------------
// Read channel
// ----------------------------------------------------------------
wire [1:0] rd_ch  = araddr[`CH_LSB+1:`CH_LSB];
wire [2:0] rd_idx = araddr[`CH_LSB-1:`IDX_LSB];
wire       rd_map = ~araddr[7] && (araddr[1:0] == 2'h0) &&
                    ({1'b0, rd_ch} < NUM_CH) && (rd_idx <= `REG_STATUS);
reg [31:0] rd_word;

always @* begin
    case (rd_idx)
        `REG_CFG:      rd_word = cfg_flat[rd_ch*32 +: 32];
        `REG_LO_LIMIT: rd_word = lo_flat[rd_ch*32 +: 32];
        `REG_HI_LIMIT: rd_word = hi_flat[rd_ch*32 +: 32];
        `REG_TOTAL:    rd_word = total_flat[rd_ch*32 +: 32];
        `REG_RATE:     rd_word = rate_flat[rd_ch*32 +: 32];
        `REG_STATUS:   rd_word = stat_flat[rd_ch*32 +: 32];
        default:       rd_word = 32'h00000000;
    endcase
end

always @(posedge clk) begin
    if (!rstn) begin
        arready <= 1'b1;
        rvalid  <= 1'b0;
        rdata   <= 32'h00000000;
        rresp   <= `RESP_OKAY;
    end else if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_map ? rd_word : 32'h00000000;
        rresp   <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
    end
end

endmodule // pulse_flow_totalizer

// *** testbench/flow_props.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Bus handshake and flag properties
// ----------------------------------------
module flow_props #(
    parameter NUM_CH = 4
) (
    input wire              clk,
    input wire              rstn,
    input wire              awvalid,
    input wire              awready,
    input wire              wvalid,
    input wire              wready,
    input wire              bvalid,
    input wire              bready,
    input wire [7:0]        araddr,
    input wire              arvalid,
    input wire              arready,
    input wire [31:0]       rdata,
    input wire              rvalid,
    input wire              rready,
    input wire [NUM_CH-1:0] lo_flag,
    input wire [NUM_CH-1:0] hi_flag
);
    a_b_hold: assert property (@(posedge clk) disable iff (!rstn)
        bvalid && !bready |=> bvalid) else $error("bvalid dropped early");
    a_r_hold: assert property (@(posedge clk) disable iff (!rstn)
        rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data moved");
    a_aw_stall: assert property (@(posedge clk) disable iff (!rstn)
        awvalid && awready |=> !awready) else $error("second address taken");
    a_b_timing: assert property (@(posedge clk) disable iff (!rstn)
        awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
        else $error("write response late");
    a_r_timing: assert property (@(posedge clk) disable iff (!rstn)
        arvalid && arready |=> rvalid && !arready) else $error("read answer late");
    a_ready_back: assert property (@(posedge clk) disable iff (!rstn)
        bvalid && bready |=> awready && wready && !bvalid) else $error("ready not back");
    a_rd_error: assert property (@(posedge clk) disable iff (!rstn)
        arvalid && arready && araddr[7] |=> rdata == 32'h0) else $error("unmapped data");
    a_reset_idle: assert property (@(posedge clk)
        !rstn |=> !bvalid && !rvalid && !(|lo_flag) && !(|hi_flag))
        else $error("busy after reset");
endmodule // flow_props

bind pulse_flow_totalizer flow_props #(.NUM_CH(NUM_CH)) u_props (
    .clk(clk), .rstn(rstn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
    .rready(rready), .lo_flag(lo_flag), .hi_flag(hi_flag)
);

// *** testbench/flow_sensor_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Pulse flowmeter sensor
// ----------------------------------------
module flow_sensor_model #(
    parameter NUM_CH = 2
) (
    input  wire              clk,
    output reg  [NUM_CH-1:0] pulse_a,
    output reg  [NUM_CH-1:0] pulse_b
);
    reg     run = 1'b0;
    integer ph = 0;
    integer sent = 0;
    initial begin
        pulse_a = {NUM_CH{1'b0}};
        pulse_b = {NUM_CH{1'b0}};
    end
    // Steady stream on channel 0, one pulse each 1000 cycles
    always @(posedge clk) begin
        if (run) begin
            ph <= (ph == 999) ? 0 : ph + 1;
            pulse_a[0] <= (ph < 500);
            if (ph == 0) begin
                sent <= sent + 1;
            end
        end
    end
    // Count line with direction level
    task dir_pulses(input integer ch, input integer n, input reg down, input integer h);
        integer i;
        begin
            pulse_b[ch] <= down;
            for (i = 0; i < n; i = i + 1) begin
                repeat (h) @(posedge clk);
                pulse_a[ch] <= 1'b1;
                repeat (h) @(posedge clk);
                pulse_a[ch] <= 1'b0;
            end
            repeat (4) @(posedge clk);
        end
    endtask
    // One quadrature cycle, a leads b when forward
    task quad_cycle(input integer ch, input reg rev);
        reg     [7:0] pat;
        integer       i;
        begin
            pat = rev ? 8'h78 : 8'hB4;
            for (i = 0; i < 4; i = i + 1) begin
                repeat (8) @(posedge clk);
                pulse_a[ch] <= pat[7-2*i];
                pulse_b[ch] <= pat[6-2*i];
            end
            repeat (8) @(posedge clk);
        end
    endtask
endmodule // flow_sensor_model

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`include "flow_totalizer_regs.vh"
module tb_top;
    reg          clk;
    reg          rstn = 1'b0;
    reg  [7:0]   awaddr = 8'h00, araddr = 8'h00;
    reg  [31:0]  wdata = 32'h0;
    reg          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    reg          arvalid = 1'b0, rready = 1'b0;
    reg  [63:0]  rst_src = 64'h0, hold_src = 64'h0, dir_src = 64'h0;
    wire         awready, wready, bvalid, arready, rvalid;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [1:0]   pulse_a, pulse_b, lo_flag, hi_flag;
    integer      n_mismatch = 0, check_count = 0, base;
    reg  [31:0]  rd;
    reg  [1:0]   rs;

    pulse_flow_totalizer #(.NUM_CH(2), .CLK_HZ(20000)) u_dut (
        .clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .pulse_a(pulse_a), .pulse_b(pulse_b),
        .reset_source_value(rst_src), .hold_source_value(hold_src),
        .dir_source_value(dir_src), .lo_flag(lo_flag), .hi_flag(hi_flag));
    flow_sensor_model #(.NUM_CH(2)) u_sensor (
        .clk(clk), .pulse_a(pulse_a), .pulse_b(pulse_b));

    // ----------------------------------------
    // Bus and checking helpers
    // ----------------------------------------
    task check(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
            end
        end
    endtask
    task bus(input reg we, input [7:0] a, input [31:0] d);
        reg     fin;
        begin
            fin = 1'b0;
            @(posedge clk);
            awaddr <= a;
            araddr <= a;
            wdata <= d;
            awvalid <= we;
            wvalid <= we;
            bready <= we;
            arvalid <= !we;
            rready <= !we;
            while (!fin) begin
                @(posedge clk);
                awvalid <= awvalid && !awready;
                wvalid <= wvalid && !wready;
                arvalid <= arvalid && !arready;
                if ((bvalid && bready) || (rvalid && rready)) begin
                    fin = 1'b1;
                    rs = we ? bresp : rresp;
                    rd = rdata;
                    bready <= 1'b0;
                    rready <= 1'b0;
                end
            end
        end
    endtask
    task rchk(input [7:0] a, input [31:0] e);
        begin
            bus(1'b0, a, 32'h0);
            check(rd, e);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", check_count, n_mismatch);
            if (n_mismatch == 0 && check_count > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_regs;
        begin
            rchk(8'h00, 32'h0);
            rchk(8'h0C, 32'h0);
            bus(1'b0, 8'h80, 32'h0);
            check({30'h0, rs}, {30'h0, `RESP_SLVERR});
            bus(1'b1, 8'h0C, 32'h5);
            check({30'h0, rs}, {30'h0, `RESP_SLVERR});
            rchk(8'h0C, 32'h0);
        end
    endtask
    task t_dir;
        begin
            u_sensor.dir_pulses(0, 5, 1'b0, 4);
            rchk(8'h0C, 32'h5);
            u_sensor.dir_pulses(0, 3, 1'b1, 4);
            rchk(8'h0C, 32'h2);
            rchk(8'h14, 32'h8);
            u_sensor.dir_pulses(0, 0, 1'b0, 4);
            u_sensor.dir_pulses(1, 2, 1'b0, 4);
            rchk(8'h2C, 32'h2);
            rchk(8'h0C, 32'h2);
            bus(1'b1, 8'h00, 32'h2000);
            rchk(8'h0C, 32'h0);
        end
    endtask
    task t_quad;
        begin
            bus(1'b1, 8'h00, 32'h1);
            u_sensor.quad_cycle(0, 1'b0);
            rchk(8'h0C, 32'h1);
            u_sensor.quad_cycle(0, 1'b1);
            rchk(8'h0C, 32'h0);
            bus(1'b1, 8'h00, 32'h2);
            u_sensor.quad_cycle(0, 1'b0);
            rchk(8'h0C, 32'h4);
            u_sensor.quad_cycle(0, 1'b1);
            rchk(8'h0C, 32'h0);
        end
    endtask
    task t_ctrl;
        begin
            bus(1'b1, 8'h00, 32'h800);
            u_sensor.dir_pulses(0, 3, 1'b0, 4);
            rchk(8'h0C, 32'h0);
            hold_src[31:0] <= 32'h1;
            u_sensor.dir_pulses(0, 3, 1'b0, 4);
            rchk(8'h0C, 32'h3);
            hold_src[31:0] <= 32'hFFFFFFFF;
            u_sensor.dir_pulses(0, 2, 1'b0, 4);
            rchk(8'h0C, 32'h3);
            bus(1'b1, 8'h00, 32'h1000);
            dir_src[31:0] <= 32'h1;
            u_sensor.dir_pulses(0, 2, 1'b0, 4);
            rchk(8'h0C, 32'h1);
            rst_src[31:0] <= 32'h1;
            rchk(8'h0C, 32'h1);
            bus(1'b1, 8'h00, 32'h400);
            rchk(8'h0C, 32'h0);
            rst_src[31:0] <= 32'h0;
        end
    endtask
    task t_filter;
        begin
            bus(1'b1, 8'h00, 32'h4);
            u_sensor.dir_pulses(0, 1, 1'b0, 300);
            rchk(8'h0C, 32'h0);
            u_sensor.dir_pulses(0, 1, 1'b0, 1500);
            rchk(8'h0C, 32'h1);
        end
    endtask
    task t_rate;
        begin
            bus(1'b1, 8'h04, 32'h1E);
            bus(1'b1, 8'h08, 32'hA);
            bus(1'b1, 8'h00, 32'h2000);
            base = u_sensor.sent;
            u_sensor.run <= 1'b1;
            repeat (41000) @(posedge clk);
            rchk(8'h10, 32'h14);
            check({31'h0, lo_flag[0]}, 32'h1);
            check({31'h0, hi_flag[0]}, 32'h1);
            bus(1'b1, 8'h00, 32'h200);
            repeat (20500) @(posedge clk);
            rchk(8'h10, 32'h11940);
            while (u_sensor.ph != 600) @(posedge clk);
            u_sensor.run <= 1'b0;
            rchk(8'h0C, u_sensor.sent - base);
            repeat (2100) @(posedge clk);
            rchk(8'h10, 32'h0);
            rchk(8'h14, 32'h5);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_dir;
        t_quad;
        t_ctrl;
        t_filter;
        t_rate;
        finish_test;
    end
    initial begin
        repeat (95000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        finish_test;
    end
endmodule // tb_top
